/* core/adc_scan_mode_sequencer.sv */
// Scan-mode decoder and mux channel sequencer with serial command capture
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps

// Functional notes
// - Code 0100 scans channels 0 up to N in ascending order, external clock, no averaging.
// - Code 0101 scans channel N up to the top channel, internal clock only.
// - Code 0110 scans channel N up to the top channel, external clock, no averaging.
// - Upper internal mode holds 16-N results on 16-channel parts and 8-N on 8-channel parts.
// - Averaging may only be active in internal clock modes, never in external ones.
// - Code 0111 scans a preset set of distinct channels ascending, internal clock, depth 16.
// - Both custom modes take their channels from the two custom scan selection registers.
// - Code 1000 does the custom ascending scan under the external clock without averaging.
// - Code 1001 runs a preset sequence of up to 256 entries under the external clock only.
// - The free sequence accepts any order, repeats and descending steps included.
// - Each free sequence entry is a 4-bit channel number and is never averaged.
// - Codes 1010 to 1111 keep the previously selected scan mode.
// - On a null code the lower eleven bits of the mode word are ignored.
// - The channel number field is plain binary, 0000 is input 0 and 1111 is input 15.
// - Code 0000 is a null code too, so an idle low data line keeps mode and channel, though its word still steps a running external scan.
module adc_scan_mode_sequencer (
	// System clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Serial link, host driven
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	// Conversion engine handshake, clk_sys domain
	input wire logic conv_start,
	input wire logic conv_done,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Sequencer outputs
	output logic [3:0] mux_channel,
	output logic conv_request,
	output logic scan_active,
	output logic ext_clock_mode,
	output logic avg_enable,
	output logic [8:0] result_count,
	output logic [3:0] mode_code
);

	// Link domain
	logic [3:0] bit_cnt;
	logic [14:0] shift;
	logic [15:0] word_hold;
	logic word_tgl;

	// Bit counter restarts whenever the host frames off
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt <= 4'h0;
		end else begin
			bit_cnt <= bit_cnt + 4'h1;
		end
	end

	always_ff @(posedge sclk or negedge nrst) begin
		if (!nrst) begin
			shift <= 15'h0000;
		end else if (!cs_n) begin
			shift <= {shift[13:0], din};
		end
	end

	// Word held stable until the next full word, long after the toggle lands
	always_ff @(posedge sclk or negedge nrst) begin
		if (!nrst) begin
			word_hold <= 16'h0000;
			word_tgl <= 1'b0;
		end else if (!cs_n && bit_cnt == 4'hf) begin
			word_hold <= {shift, din};
			word_tgl <= ~word_tgl;
		end
	end

	// Crossing into clk_sys
	logic tgl_s1;
	logic tgl_s2;
	logic tgl_s3;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			tgl_s1 <= 1'b0;
			tgl_s2 <= 1'b0;
			tgl_s3 <= 1'b0;
		end else begin
			tgl_s1 <= word_tgl;
			tgl_s2 <= tgl_s1;
			tgl_s3 <= tgl_s2;
		end
	end

	logic word_evt;
	logic cmd_is_mode;
	logic [3:0] word_code;
	logic code_is_null;

	assign word_evt = tgl_s2 ^ tgl_s3;
	assign cmd_is_mode = word_evt && !word_hold[scan_seq_pkg::CMD_SEL_BIT];
	assign word_code = word_hold[scan_seq_pkg::SCAN_MSB:scan_seq_pkg::SCAN_LSB];
	assign code_is_null = (word_code == scan_seq_pkg::SCAN_NULL0) ||
		(word_code >= scan_seq_pkg::SCAN_NULL_FIRST);

	// Register file
	logic [1:0] ctrl;
	logic [7:0] custom0;
	logic [7:0] custom1;
	logic [7:0] seq_len;
	logic [7:0] seq_ptr;
	logic [3:0] seq_mem [scan_seq_pkg::SEQ_DEPTH];
	logic [3:0] chan_n;
	logic [7:0] seq_idx;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ctrl <= scan_seq_pkg::CTRL_RESET;
			custom0 <= scan_seq_pkg::CUSTOM_RESET;
			custom1 <= scan_seq_pkg::CUSTOM_RESET;
			seq_len <= scan_seq_pkg::SEQ_LEN_RESET;
		end else if (reg_wr) begin
			case (reg_addr)
				scan_seq_pkg::REG_CTRL: ctrl <= reg_wdata[1:0];
				scan_seq_pkg::REG_CUSTOM0: custom0 <= reg_wdata[7:0];
				scan_seq_pkg::REG_CUSTOM1: custom1 <= reg_wdata[7:0];
				scan_seq_pkg::REG_SEQ_LEN: seq_len <= reg_wdata[7:0];
				default: ;
			endcase
		end
	end

	// Pointer auto-increments so a sequence loads as a burst of data writes
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			seq_ptr <= 8'h00;
		end else if (reg_wr && reg_addr == scan_seq_pkg::REG_SEQ_PTR) begin
			seq_ptr <= reg_wdata[7:0];
		end else if (reg_wr && reg_addr == scan_seq_pkg::REG_SEQ_DATA) begin
			seq_ptr <= seq_ptr + 8'h01;
		end
	end

	// Any order and repeats are stored as given
	always_ff @(posedge clk_sys) begin
		if (reg_wr && reg_addr == scan_seq_pkg::REG_SEQ_DATA) begin
			seq_mem[seq_ptr] <= reg_wdata[3:0];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				scan_seq_pkg::REG_CTRL: reg_rdata <= {14'h0000, ctrl};
				scan_seq_pkg::REG_CUSTOM0: reg_rdata <= {8'h00, custom0};
				scan_seq_pkg::REG_CUSTOM1: reg_rdata <= {8'h00, custom1};
				scan_seq_pkg::REG_SEQ_LEN: reg_rdata <= {8'h00, seq_len};
				scan_seq_pkg::REG_SEQ_PTR: reg_rdata <= {8'h00, seq_ptr};
				scan_seq_pkg::REG_STATUS: reg_rdata <= {2'h0, scan_active, ext_clock_mode,
					chan_n, mode_code, mux_channel};
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// Mode decode
	logic start_req;

	// Null codes leave both mode and channel number untouched
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mode_code <= scan_seq_pkg::SCAN_NULL0;
			chan_n <= 4'h0;
			start_req <= 1'b0;
		end else begin
			start_req <= cmd_is_mode && !code_is_null;
			if (cmd_is_mode && !code_is_null) begin
				mode_code <= word_code;
				chan_n <= word_hold[scan_seq_pkg::CHAN_MSB:scan_seq_pkg::CHAN_LSB];
			end
		end
	end

	logic [3:0] top_ch;
	logic [3:0] n_clamp;
	logic [15:0] custom_mask;
	logic [15:0] sel_vec;
	logic mode_ext;
	logic mode_int;
	logic mode_free;

	assign top_ch = ctrl[scan_seq_pkg::CTRL_PART16_BIT] ? scan_seq_pkg::TOP_CH_16 :
		scan_seq_pkg::TOP_CH_8;
	assign n_clamp = (chan_n > top_ch) ? top_ch : chan_n;
	assign custom_mask = {custom1, custom0};
	assign mode_free = mode_code == scan_seq_pkg::SCAN_FREE;
	assign mode_int = (mode_code == scan_seq_pkg::SCAN_UPPER_INT) ||
		(mode_code == scan_seq_pkg::SCAN_CUSTOM_INT);
	assign mode_ext = (mode_code == scan_seq_pkg::SCAN_STD_EXT) ||
		(mode_code == scan_seq_pkg::SCAN_UPPER_EXT) ||
		(mode_code == scan_seq_pkg::SCAN_CUSTOM_EXT) || mode_free;

	function automatic logic [15:0] range_vec(input logic [3:0] lo, input logic [3:0] hi);
		logic [15:0] v;
		v = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			if (4'(i) >= lo && 4'(i) <= hi) begin
				v[i] = 1'b1;
			end
		end
		return v;
	endfunction : range_vec

	// Lowest set bit at or above the start point, found flag on top
	function automatic logic [4:0] pick_from(input logic [15:0] vec, input logic [3:0] from);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 15; i >= 0; i--) begin
			if (vec[i] && 4'(i) >= from) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction : pick_from

	function automatic logic [4:0] popcount(input logic [15:0] vec);
		logic [4:0] c;
		c = 5'h00;
		for (int i = 0; i < 16; i++) begin
			c = c + {4'h0, vec[i]};
		end
		return c;
	endfunction : popcount

	always_comb begin
		unique case (mode_code)
			scan_seq_pkg::SCAN_STD_EXT: sel_vec = range_vec(4'h0, n_clamp);
			scan_seq_pkg::SCAN_UPPER_INT,
			scan_seq_pkg::SCAN_UPPER_EXT: sel_vec = range_vec(n_clamp, top_ch);
			// Mask bits hold unique channels, so order is ascending by construction
			scan_seq_pkg::SCAN_CUSTOM_INT,
			scan_seq_pkg::SCAN_CUSTOM_EXT: sel_vec = custom_mask &
				range_vec(4'h0, top_ch);
			default: sel_vec = 16'h0000;
		endcase
	end

	// Sequencer
	scan_seq_pkg::seq_state_t state;
	logic step_now;
	logic [4:0] first_pick;
	logic [4:0] next_pick;
	logic [3:0] free_first;
	logic [3:0] free_next;
	logic [7:0] idx_next;

	assign idx_next = seq_idx + 8'h01;
	assign free_first = (seq_mem[0] > top_ch) ? top_ch : seq_mem[0];
	assign free_next = (seq_mem[idx_next] > top_ch) ? top_ch : seq_mem[idx_next];
	assign first_pick = pick_from(sel_vec, 4'h0);
	assign next_pick = (mux_channel == top_ch) ? 5'h00 :
		pick_from(sel_vec, mux_channel + 4'h1);
	// External modes step once per received 16-bit word, internal ones per finished conversion
	assign step_now = (state == scan_seq_pkg::ST_RUN) && !start_req &&
		(mode_ext ? word_evt : conv_done);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state <= scan_seq_pkg::ST_IDLE;
			mux_channel <= 4'h0;
			seq_idx <= 8'h00;
			conv_request <= 1'b0;
		end else begin
			conv_request <= 1'b0;
			unique case (state)
				scan_seq_pkg::ST_IDLE: begin
					if ((start_req && mode_ext) || (conv_start && mode_int)) begin
						seq_idx <= 8'h00;
						if (mode_free) begin
							mux_channel <= free_first;
							conv_request <= 1'b1;
							state <= scan_seq_pkg::ST_RUN;
						end else if (first_pick[4]) begin
							mux_channel <= first_pick[3:0];
							conv_request <= 1'b1;
							state <= scan_seq_pkg::ST_RUN;
						end
					end
				end
				scan_seq_pkg::ST_RUN: begin
					if (start_req) begin
						// A new mode word ends the running scan
						state <= scan_seq_pkg::ST_IDLE;
					end else if (step_now) begin
						if (mode_free) begin
							if (seq_idx == seq_len) begin
								state <= scan_seq_pkg::ST_IDLE;
							end else begin
								seq_idx <= idx_next;
								mux_channel <= free_next;
								conv_request <= 1'b1;
							end
						end else if (next_pick[4]) begin
							mux_channel <= next_pick[3:0];
							conv_request <= 1'b1;
						end else begin
							state <= scan_seq_pkg::ST_IDLE;
						end
					end
				end
				default: state <= scan_seq_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			scan_active <= 1'b0;
		end else begin
			scan_active <= (state == scan_seq_pkg::ST_RUN) || conv_request;
		end
	end

	// Averaging is blocked outright in every external mode
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ext_clock_mode <= 1'b0;
			avg_enable <= 1'b0;
		end else begin
			ext_clock_mode <= mode_ext;
			avg_enable <= mode_int && ctrl[scan_seq_pkg::CTRL_AVG_BIT];
		end
	end

	logic [8:0] upper_expect;
	assign upper_expect = {5'h00, top_ch} + 9'h001 - {5'h00, n_clamp};

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			result_count <= 9'h000;
		end else if (mode_free) begin
			result_count <= {1'b0, seq_len} + 9'h001;
		end else if (mode_code == scan_seq_pkg::SCAN_UPPER_INT ||
			mode_code == scan_seq_pkg::SCAN_UPPER_EXT) begin
			result_count <= upper_expect;
		end else begin
			result_count <= {4'h0, popcount(sel_vec)};
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	chk_ext_no_avg: assert property (ext_clock_mode |-> !avg_enable)
		else $error("averaging active in an external clock mode");
	chk_std_first: assert property (start_req && state == scan_seq_pkg::ST_IDLE &&
		mode_code == scan_seq_pkg::SCAN_STD_EXT |=> conv_request && mux_channel == 4'h0)
		else $error("ascending scan did not start at channel 0");
	chk_upper_first: assert property (start_req && state == scan_seq_pkg::ST_IDLE &&
		mode_code == scan_seq_pkg::SCAN_UPPER_EXT |=> mux_channel == $past(n_clamp))
		else $error("upper scan did not start at channel N");
	chk_upper_count: assert property (mode_code == scan_seq_pkg::SCAN_UPPER_INT &&
		$stable(mode_code) |=> result_count == $past(upper_expect))
		else $error("upper scan result count wrong");
	chk_custom_set: assert property (scan_active && state == scan_seq_pkg::ST_RUN &&
		!start_req && (mode_code == scan_seq_pkg::SCAN_CUSTOM_INT ||
		mode_code == scan_seq_pkg::SCAN_CUSTOM_EXT) |-> custom_mask[mux_channel])
		else $error("custom scan selected a channel outside the mask");
	chk_ascend_step: assert property (step_now && !mode_free |=>
		state == scan_seq_pkg::ST_IDLE || mux_channel > $past(mux_channel))
		else $error("scan step was not ascending");
	chk_null_hold: assert property (cmd_is_mode && code_is_null |=>
		$stable(mode_code) && $stable(chan_n))
		else $error("null code changed the scan mode");
	chk_chan_binary: assert property (cmd_is_mode && !code_is_null |=>
		chan_n == $past(word_hold[scan_seq_pkg::CHAN_MSB:scan_seq_pkg::CHAN_LSB]) &&
		mode_code == $past(word_code))
		else $error("channel number not taken as plain binary");
	chk_free_walk: assert property (step_now && mode_free && seq_idx != seq_len
		|=> seq_idx == $past(idx_next) && conv_request ##1 !conv_request)
		else $error("free sequence did not advance one entry");
	chk_top_clamp: assert property (state == scan_seq_pkg::ST_RUN |->
		mux_channel <= top_ch)
		else $error("channel above the part's top channel");

endmodule : adc_scan_mode_sequencer

/* core/scan_seq_pkg.sv */
// Shared constants for the scan-mode decoder and channel sequencer
package scan_seq_pkg;
	// Serial command word layout
	localparam int WORD_BITS = 16;
	localparam int CMD_SEL_BIT = 15;
	localparam int SCAN_MSB = 14;
	localparam int SCAN_LSB = 11;
	localparam int CHAN_MSB = 10;
	localparam int CHAN_LSB = 7;

	// Scan codes
	localparam logic [3:0] SCAN_NULL0 = 4'h0;
	localparam logic [3:0] SCAN_STD_EXT = 4'h4;
	localparam logic [3:0] SCAN_UPPER_INT = 4'h5;
	localparam logic [3:0] SCAN_UPPER_EXT = 4'h6;
	localparam logic [3:0] SCAN_CUSTOM_INT = 4'h7;
	localparam logic [3:0] SCAN_CUSTOM_EXT = 4'h8;
	localparam logic [3:0] SCAN_FREE = 4'h9;
	localparam logic [3:0] SCAN_NULL_FIRST = 4'ha;

	// Highest channel per part size
	localparam logic [3:0] TOP_CH_16 = 4'hf;
	localparam logic [3:0] TOP_CH_8 = 4'h7;

	// Register port map (word indices)
	localparam int REG_ADDR_BITS = 3;
	localparam int REG_DATA_BITS = 16;
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_CUSTOM0 = 3'h1;
	localparam logic [2:0] REG_CUSTOM1 = 3'h2;
	localparam logic [2:0] REG_SEQ_LEN = 3'h3;
	localparam logic [2:0] REG_SEQ_PTR = 3'h4;
	localparam logic [2:0] REG_SEQ_DATA = 3'h5;
	localparam logic [2:0] REG_STATUS = 3'h6;

	// Control register fields and reset values
	localparam int CTRL_AVG_BIT = 0;
	localparam int CTRL_PART16_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h2;
	localparam logic [7:0] CUSTOM_RESET = 8'h00;
	localparam logic [7:0] SEQ_LEN_RESET = 8'h00;

	// Free-sequence memory depth
	localparam int SEQ_DEPTH = 256;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} seq_state_t;
endpackage : scan_seq_pkg

/* tb/host_serial_model.sv */
// Host side of the three-wire command link
`timescale 1ns/1ps
module host_serial_model (
	// Link pins
	output logic sclk,
	output logic cs_n,
	output logic din
);
	localparam time HALF = 16ns;

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b1;
	end

	// Clock stands low outside frames; data moves on the falling half
	task automatic send_word(input logic [15:0] w);
		#7;
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			din = w[i];
			#HALF sclk = 1'b1;
			#HALF sclk = 1'b0;
		end
		cs_n = 1'b1;
		// Released line shows the inverse, never a stale bit
		din = ~din;
	endtask : send_word
endmodule : host_serial_model

/* tb/adc_scan_mode_sequencer_test.sv */
// Self-checking bench for the scan-mode sequencer
`timescale 1ns/1ps
module adc_scan_mode_sequencer_test;
	logic clk_sys, nrst, sclk, cs_n, din, conv_start, conv_done, reg_wr, reg_rd;
	logic [2:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, mask, st;
	logic [3:0] mux_channel, mode_code;
	logic conv_request, scan_active, ext_clock_mode, avg_enable, part16, avg_on;
	logic [8:0] result_count;
	logic [31:0] seed = 32'h00011e17;
	int err_total = 0;
	int cmp_count = 0;
	int reqs = 0;
	int cycles = 0;
	int exp_q[$];
	logic [3:0] seq [256];

	adc_scan_mode_sequencer dut (.clk_sys(clk_sys), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
		.din(din), .conv_start(conv_start), .conv_done(conv_done), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.mux_channel(mux_channel), .conv_request(conv_request), .scan_active(scan_active),
		.ext_clock_mode(ext_clock_mode), .avg_enable(avg_enable),
		.result_count(result_count), .mode_code(mode_code));
	host_serial_model host (.sclk(sclk), .cs_n(cs_n), .din(din));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (conv_request === 1'b1) reqs <= reqs + 1;
		if (cycles == 95000) begin
			err_total++;
			finish_test();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask : rd

	task automatic pulse(input bit done);
		@(posedge clk_sys);
		conv_done <= done;
		conv_start <= !done;
		@(posedge clk_sys);
		conv_done <= 1'b0;
		conv_start <= 1'b0;
	endtask : pulse

	// Word lands a few system edges after its last bit; margin kept generous
	task automatic settle();
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : settle

	function automatic void build_exp(input logic [3:0] code, input logic [3:0] n,
		input int len);
		int top = part16 ? 15 : 7;
		int nn = (n > top) ? top : n;
		exp_q.delete();
		case (code)
			4'h4: for (int c = 0; c <= nn; c++) exp_q.push_back(c);
			4'h5, 4'h6: for (int c = nn; c <= top; c++) exp_q.push_back(c);
			4'h7, 4'h8: for (int c = 0; c <= top; c++) if (mask[c]) exp_q.push_back(c);
			default: for (int i = 0; i < len; i++) exp_q.push_back(seq[i] > top ? top : seq[i]);
		endcase
	endfunction : build_exp

	// One mode word, then the whole scan; ticks pace external modes
	task automatic run(input logic [3:0] code, input logic [3:0] n, input int len);
		logic [31:0] t;
		int r0;
		bit ext;
		ext = (code != 4'h5 && code != 4'h7);
		build_exp(code, n, len);
		r0 = reqs;
		t = rnd();
		host.send_word({1'b0, code, n, t[6:0]});
		settle();
		check(mode_code, code);
		check(ext_clock_mode, ext);
		check(avg_enable, !ext && avg_on);
		check(result_count, exp_q.size());
		rd(3'h6, st);
		if (n <= (part16 ? 15 : 7)) check(st[11:8], n);
		if (!ext) pulse(1'b0);
		for (int i = 0; i < exp_q.size(); i++) begin
			t = rnd();
			if (i > 0 && ext) host.send_word({1'b1, t[14:0]});
			if (i > 0 && !ext) pulse(1'b1);
			settle();
			check(mux_channel, exp_q[i]);
			check(scan_active, 1'b1);
			check(mode_code, code);
		end
		if (ext) host.send_word(16'h8000);
		else pulse(1'b1);
		settle();
		check(scan_active, 1'b0);
		check(reqs - r0, exp_q.size());
	endtask : run

	initial begin
		logic [31:0] t;
		logic [3:0] code;
		nrst = 1'b0;
		conv_start = 1'b0;
		conv_done = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		rd(3'h0, st);
		check(st, 16'h0002);
		rd(3'h7, st);
		check(st, 16'h0000);
		wr(3'h6, 16'hffff);
		rd(3'h6, st);
		check(st, 16'h0000);
		check(mode_code, 4'h0);
		$display("Test reset and map done");
		part16 = 1'b1;
		avg_on = 1'b1;
		wr(3'h0, 16'h0003);
		for (int k = 0; k < 16; k++) run(k[0] ? 4'h6 : 4'h4, k[3:0], 0);
		$display("Test ascending and upper scans done");
		run(4'h5, 4'h0, 0);
		t = rnd();
		run(4'h5, t[3:0], 0);
		// Null words: low bits random, mode and channel must stay
		for (int k = 9; k < 16; k++) begin
			code = (k == 9) ? 4'h0 : k[3:0];
			t = rnd();
			host.send_word({1'b0, code, t[10:0]});
			settle();
			check(mode_code, 4'h5);
			rd(3'h6, st);
			check(st[11:8], exp_q[0]);
		end
		$display("Test null codes done");
		part16 = 1'b0;
		avg_on = 1'b0;
		wr(3'h0, 16'h0000);
		run(4'h5, 4'h3, 0);
		run(4'h6, 4'ha, 0);
		run(4'h4, 4'hc, 0);
		mask = 16'hff5a;
		wr(3'h1, {8'h00, mask[7:0]});
		wr(3'h2, {8'h00, mask[15:8]});
		run(4'h8, 4'h2, 0);
		$display("Test small part done");
		part16 = 1'b1;
		avg_on = 1'b1;
		wr(3'h0, 16'h0003);
		mask = 16'hffff;
		wr(3'h1, {8'h00, mask[7:0]});
		wr(3'h2, {8'h00, mask[15:8]});
		run(4'h7, 4'h9, 0);
		t = rnd();
		mask = t[15:0] | 16'h0101;
		wr(3'h1, {8'h00, mask[7:0]});
		wr(3'h2, {8'h00, mask[15:8]});
		run(4'h7, 4'h0, 0);
		run(4'h8, 4'hf, 0);
		$display("Test custom sets done");
		wr(3'h3, 16'h00ff);
		wr(3'h4, 16'h0000);
		for (int i = 0; i < 256; i++) begin
			t = rnd();
			seq[i] = (i < 2) ? 4'h9 : t[3:0];
			if (i == 2) seq[i] = 4'h3;
			wr(3'h5, {t[27:16], seq[i]});
		end
		rd(3'h5, st);
		check(st, 16'h0000);
		run(4'h9, 4'h0, 256);
		$display("Test free sequence done");
		finish_test();
	end
endmodule : adc_scan_mode_sequencer_test
